/* File: sac_pkg.sv */
/*
 * Constants for the converter sequencer control block: register byte
 * addresses, field positions, reset values and mode codes.
 * Assumes an APB slave with 32-bit data; registers are 16 bits in the low half.
 */
// Contract
// - Simultaneous sampling takes all four channels (count 1x) or channels 0 and 1 (01).
// - In 12-bit mode simultaneous bit, channel count and channel 1-3 selects read zero.
// - Auto-start sets the sampling bit right after a conversion finishes.
// - Trigger 000 ends sampling by software clear; other triggers clear it by hardware.
// - Done flag sets when conversion completes, clears when a new one starts.
// - Software writing zero clears done; writing one never sets it.
// - Reference select 000/001/010/011 pick references; 1xx acts as 000.
// - Scan enable steps channel 0 positive input through scan list in set A.
// - Channel count 00 converts channel 0, 01 channels 0-1, 1x channels 0-3.
// - Buffer half status reads one while second half fills in split mode.
// - Increment field N steps DMA address every N+1 operations.
// - Split mode alternates buffer halves each step, else restarts at start.
// - Alternate mode uses set A then set B selects alternately.
// - Clock source one picks RC clock and ignores divider; zero uses divider.
// - Auto sample time counts 0-31 conversion clocks when trigger is internal counter.
// - Conversion clock period is instruction period times divider plus one.
// - DMA buffer length field gives two to its value words per input.
// - Channel 1-3 positive select picks inputs 0-2 when zero, 3-5 when one.
// - Channel 1-3 negative select 0x reference, 10 inputs 6-8, 11 inputs 9-11.
// - Channel 0 negative select one picks input 1, zero picks reference.
// - Channel 0 positive select picks input 0-31 by value.
// - Trigger source 000 software, 001 pin, 010 timer, 011 PWM, 111 counter.
// - Resolution bit one is 12-bit single channel, zero 10-bit four channel.
package sac_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CON1 = 8'h00;
  localparam logic [7:0] ADDR_CON2 = 8'h04;
  localparam logic [7:0] ADDR_CON3 = 8'h08;
  localparam logic [7:0] ADDR_CON4 = 8'h0C;
  localparam logic [7:0] ADDR_CHS123 = 8'h10;
  localparam logic [7:0] ADDR_CHS0 = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam logic [4:0] SCAN_PTR_RESET = 5'h1F;
  // Writable masks; the hardware-owned bits are handled separately.
  localparam logic [15:0] MASK_CON1 = 16'hB7EC;
  localparam logic [15:0] MASK_CON2 = 16'hE73F;
  localparam logic [15:0] MASK_CON3 = 16'h9FFF;
  localparam logic [15:0] MASK_CON4 = 16'h0007;
  localparam logic [15:0] MASK_CHS123 = 16'h0707;
  localparam logic [15:0] MASK_CHS0 = 16'h9F9F;
  localparam int BIT_ON = 15;
  localparam int BIT_RES = 10;
  localparam int BIT_SIM = 3;
  localparam int BIT_SAMPLE_AUTO_START = 2;
  localparam int BIT_SAMPLING_BIT = 1;
  localparam int BIT_DONE = 0;
  localparam int BIT_SCAN = 10;
  localparam int BIT_BUFFER_HALF_STATUS = 7;
  localparam int BIT_SPLIT_BUFFER_MODE = 1;
  localparam int BIT_ALTERNATE_SAMPLE_MODE = 0;
  localparam int BIT_RC = 15;
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_TMR = 3'h2;
  localparam logic [2:0] TRIG_PWM = 3'h3;
  localparam logic [2:0] TRIG_CNT = 3'h7;
  localparam logic [7:0] DIV_MAX = 8'h3F;
  // Last conversion clock count for each resolution; a conversion lasts one period more.
  localparam logic [3:0] CONV_TAD_10 = 4'hC;
  localparam logic [3:0] CONV_TAD_12 = 4'hE;
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_CONVERT = 3'b100
  } sac_state_e;
endpackage : sac_pkg

/* File: sac_top.sv */
/*
 * Sequencer control for one successive-approximation converter: APB
 * registers, sample/convert sequencing, conversion clock, input selects and
 * DMA address stepping.
 * Assumes triggers, RC clock tick and scan list arrive synchronous to clock.
 */
// The register addresses and the APB interface to the registers were decided locally.
module sac_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_pin,
  input wire logic trig_timer,
  input wire logic trig_pwm,
  input wire logic rc_tick,
  input wire logic [31:0] scan_list,
  output logic sampling,
  output logic converting,
  output logic [1:0] active_channel,
  output logic simultaneous,
  output logic [4:0] ch0_pos,
  output logic ch0_neg_input,
  output logic [3:0] ch123_pos_base,
  output logic [3:0] ch123_neg_base,
  output logic ch123_neg_is_ref,
  output logic ext_ref_pos,
  output logic ext_ref_neg,
  output logic dma_step,
  output logic [3:0] buffer_words_log
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] con1_reg, con2_reg, con3_reg, con4_reg, chs123_reg, chs0_reg;
  logic sampling_bit_reg, done_reg, buffer_half_status_reg, alt_b_reg;
  logic [7:0] tad_cnt_reg;
  logic tad_tick;
  logic [4:0] auto_sample_time_cnt_reg;
  logic [3:0] conv_cnt_reg, increment_rate_field_cnt_reg;
  logic [4:0] scan_ptr_reg;
  logic [1:0] chan_cnt_reg;
  sac_pkg::sac_state_e state_reg;
  logic wr, rd, mapped;
  logic res12, on, trig_hw, start_conv, conv_end;
  logic [2:0] trigger_source_sel;
  logic [1:0] channel_count_sel_eff;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign on = con1_reg[sac_pkg::BIT_ON];
  assign res12 = con1_reg[sac_pkg::BIT_RES];
  assign trigger_source_sel = con1_reg[7:5];
  assign channel_count_sel_eff = res12 ? 2'h0 : con2_reg[9:8];
  assign mapped = paddr <= sac_pkg::ADDR_STAT && paddr[1:0] == 2'h0;

  // ****************************************************************
  // Bus slave: zero wait states, error on unmapped address
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      con1_reg <= sac_pkg::RESET_VAL;
      con2_reg <= sac_pkg::RESET_VAL;
      con3_reg <= sac_pkg::RESET_VAL;
      con4_reg <= sac_pkg::RESET_VAL;
      chs123_reg <= sac_pkg::RESET_VAL;
      chs0_reg <= sac_pkg::RESET_VAL;
    end else if (wr) begin
      unique case (paddr)
        sac_pkg::ADDR_CON1: con1_reg <= pwdata[15:0] & sac_pkg::MASK_CON1;
        sac_pkg::ADDR_CON2: con2_reg <= pwdata[15:0] & sac_pkg::MASK_CON2;
        sac_pkg::ADDR_CON3: con3_reg <= pwdata[15:0] & sac_pkg::MASK_CON3;
        sac_pkg::ADDR_CON4: con4_reg <= pwdata[15:0] & sac_pkg::MASK_CON4;
        sac_pkg::ADDR_CHS123: chs123_reg <= pwdata[15:0] & sac_pkg::MASK_CHS123;
        sac_pkg::ADDR_CHS0: chs0_reg <= pwdata[15:0] & sac_pkg::MASK_CHS0;
        default: ;
      endcase
    end
  end

  // Read view hides fields that do not exist in 12-bit mode.
  logic [15:0] rd_view;
  always_comb begin
    rd_view = 16'h0000;
    unique case (paddr)
      sac_pkg::ADDR_CON1: begin
        rd_view = con1_reg;
        rd_view[sac_pkg::BIT_SIM] = con1_reg[sac_pkg::BIT_SIM] & !res12;
        rd_view[sac_pkg::BIT_SAMPLING_BIT] = sampling_bit_reg;
        rd_view[sac_pkg::BIT_DONE] = done_reg;
      end
      sac_pkg::ADDR_CON2: begin
        rd_view = {con2_reg[15:10], channel_count_sel_eff, buffer_half_status_reg, con2_reg[6:0]};
      end
      sac_pkg::ADDR_CON3: rd_view = con3_reg;
      sac_pkg::ADDR_CON4: rd_view = con4_reg;
      sac_pkg::ADDR_CHS123: rd_view = res12 ? 16'h0000 : chs123_reg;
      sac_pkg::ADDR_CHS0: rd_view = chs0_reg;
      sac_pkg::ADDR_STAT: rd_view = {11'h000, scan_ptr_reg};
      default: rd_view = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (rd && !penable) ? {16'h0000, rd_view} : 32'h00000000;
    end
  end

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  // Divider counts instruction clocks; reserved divider values are clamped.
  logic [7:0] div_eff;
  assign div_eff = con3_reg[7:0] > sac_pkg::DIV_MAX ? sac_pkg::DIV_MAX : con3_reg[7:0];
  // The count rests in RC mode and wraps at or above the limit, so a smaller divider takes effect at once.
  assign tad_tick = con3_reg[sac_pkg::BIT_RC] ? rc_tick : (tad_cnt_reg >= div_eff);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tad_cnt_reg <= 8'h00;
    end else if (!on || tad_tick || con3_reg[sac_pkg::BIT_RC]) begin
      tad_cnt_reg <= 8'h00;
    end else begin
      tad_cnt_reg <= tad_cnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Sample and convert sequence
  // ****************************************************************
  always_comb begin
    unique case (trigger_source_sel)
      sac_pkg::TRIG_PIN: trig_hw = trig_pin;
      sac_pkg::TRIG_TMR: trig_hw = trig_timer;
      sac_pkg::TRIG_PWM: trig_hw = trig_pwm;
      sac_pkg::TRIG_CNT: trig_hw = tad_tick && auto_sample_time_cnt_reg == con3_reg[12:8];
      default: trig_hw = 1'b0;
    endcase
  end
  logic sw_sampling_bit_wr;
  assign sw_sampling_bit_wr = wr && paddr == sac_pkg::ADDR_CON1;
  assign start_conv = state_reg == sac_pkg::SAC_SAMPLE &&
    (trigger_source_sel == sac_pkg::TRIG_SW ? (sw_sampling_bit_wr && !pwdata[sac_pkg::BIT_SAMPLING_BIT]) : trig_hw);
  assign conv_end = state_reg == sac_pkg::SAC_CONVERT && tad_tick &&
    conv_cnt_reg == (res12 ? sac_pkg::CONV_TAD_12 : sac_pkg::CONV_TAD_10) &&
    (con1_reg[sac_pkg::BIT_SIM] || chan_cnt_reg == channel_count_sel_eff_max(channel_count_sel_eff));

  function automatic logic [1:0] channel_count_sel_eff_max(input logic [1:0] c);
    channel_count_sel_eff_max = c[1] ? 2'h3 : {1'b0, c[0]};
  endfunction : channel_count_sel_eff_max

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= sac_pkg::SAC_IDLE;
      sampling_bit_reg <= 1'b0;
    end else if (!on) begin
      state_reg <= sac_pkg::SAC_IDLE;
      sampling_bit_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        sac_pkg::SAC_IDLE: begin
          if ((sw_sampling_bit_wr && pwdata[sac_pkg::BIT_SAMPLING_BIT]) || con1_reg[sac_pkg::BIT_SAMPLE_AUTO_START]) begin
            state_reg <= sac_pkg::SAC_SAMPLE;
            sampling_bit_reg <= 1'b1;
          end
        end
        sac_pkg::SAC_SAMPLE: begin
          if (start_conv) begin
            state_reg <= sac_pkg::SAC_CONVERT;
            sampling_bit_reg <= 1'b0;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          if (conv_end) begin
            state_reg <= con1_reg[sac_pkg::BIT_SAMPLE_AUTO_START] ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
            sampling_bit_reg <= con1_reg[sac_pkg::BIT_SAMPLE_AUTO_START];
          end
        end
      endcase
    end
  end

  // Sample time and conversion length counters, both in conversion clocks.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      auto_sample_time_cnt_reg <= 5'h00;
      conv_cnt_reg <= 4'h0;
      chan_cnt_reg <= 2'h0;
    end else begin
      if (state_reg != sac_pkg::SAC_SAMPLE) begin
        auto_sample_time_cnt_reg <= 5'h00;
      end else if (tad_tick && auto_sample_time_cnt_reg != 5'h1F) begin
        auto_sample_time_cnt_reg <= auto_sample_time_cnt_reg + 5'h01;
      end
      if (state_reg != sac_pkg::SAC_CONVERT) begin
        conv_cnt_reg <= 4'h0;
        chan_cnt_reg <= 2'h0;
      end else if (tad_tick) begin
        if (conv_cnt_reg == (res12 ? sac_pkg::CONV_TAD_12 : sac_pkg::CONV_TAD_10)) begin
          conv_cnt_reg <= 4'h0;
          chan_cnt_reg <= chan_cnt_reg + 2'h1;
        end else begin
          conv_cnt_reg <= conv_cnt_reg + 4'h1;
        end
      end
    end
  end

  // Set beats a software clear in the same cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else if (conv_end) begin
      done_reg <= 1'b1;
    end else if (start_conv) begin
      done_reg <= 1'b0;
    end else if (sw_sampling_bit_wr && !pwdata[sac_pkg::BIT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Sample sets, scan, buffer stepping
  // ****************************************************************
  // The pointer holds the last scanned input; reset parks it on the top input,
  // so the lowest selected input is converted first.
  logic [4:0] scan_next;
  always_comb begin
    scan_next = scan_ptr_reg;
    for (int i = 1; i <= 32; i++) begin
      if (scan_next == scan_ptr_reg && scan_list[5'(scan_ptr_reg + 5'(i))]) begin
        scan_next = 5'(scan_ptr_reg + 5'(i));
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alt_b_reg <= 1'b0;
      scan_ptr_reg <= sac_pkg::SCAN_PTR_RESET;
      increment_rate_field_cnt_reg <= 4'h0;
      buffer_half_status_reg <= 1'b0;
      dma_step <= 1'b0;
    end else begin
      dma_step <= 1'b0;
      if (conv_end) begin
        alt_b_reg <= con2_reg[sac_pkg::BIT_ALTERNATE_SAMPLE_MODE] && !alt_b_reg;
        if (!alt_b_reg && con2_reg[sac_pkg::BIT_SCAN]) begin
          scan_ptr_reg <= scan_next;
        end
        if (increment_rate_field_cnt_reg == con2_reg[5:2]) begin
          increment_rate_field_cnt_reg <= 4'h0;
          dma_step <= 1'b1;
          buffer_half_status_reg <= con2_reg[sac_pkg::BIT_SPLIT_BUFFER_MODE] && !buffer_half_status_reg;
        end else begin
          increment_rate_field_cnt_reg <= increment_rate_field_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Registered selects toward the analog front end
  // ****************************************************************
  logic [7:0] set_sel0;
  logic [2:0] set_sel123;
  assign set_sel0 = alt_b_reg ? chs0_reg[15:8] : chs0_reg[7:0];
  assign set_sel123 = alt_b_reg ? chs123_reg[10:8] : chs123_reg[2:0];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sampling <= 1'b0;
      converting <= 1'b0;
      active_channel <= 2'h0;
      simultaneous <= 1'b0;
      ch0_pos <= 5'h00;
      ch0_neg_input <= 1'b0;
      ch123_pos_base <= 4'h0;
      ch123_neg_base <= 4'h0;
      ch123_neg_is_ref <= 1'b1;
      ext_ref_pos <= 1'b0;
      ext_ref_neg <= 1'b0;
      buffer_words_log <= 4'h0;
    end else begin
      sampling <= sampling_bit_reg;
      converting <= state_reg == sac_pkg::SAC_CONVERT;
      active_channel <= chan_cnt_reg;
      simultaneous <= con1_reg[sac_pkg::BIT_SIM] && !res12 && channel_count_sel_eff != 2'h0;
      ch0_pos <= (!alt_b_reg && con2_reg[sac_pkg::BIT_SCAN]) ? scan_next : set_sel0[4:0];
      ch0_neg_input <= set_sel0[7];
      ch123_pos_base <= set_sel123[0] ? 4'h3 : 4'h0;
      ch123_neg_is_ref <= !set_sel123[2];
      ch123_neg_base <= set_sel123[1] ? 4'h9 : 4'h6;
      ext_ref_pos <= !con2_reg[15] && con2_reg[13];
      ext_ref_neg <= !con2_reg[15] && con2_reg[14];
      buffer_words_log <= {1'b0, con4_reg[2:0]};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_done_on_end: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end |=> done_reg) else $error("done not set after conversion");
  a_done_no_sw_set: assert property (@(posedge clock) disable iff (!reset_n)
    !done_reg && !conv_end |=> !done_reg) else $error("done set without conversion");
  a_auto_restart: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end && con1_reg[sac_pkg::BIT_SAMPLE_AUTO_START] && on |=> sampling_bit_reg) else $error("auto start missed");
  a_sampling_bit_clear: assert property (@(posedge clock) disable iff (!reset_n)
    start_conv && on |=> !sampling_bit_reg ##1 !sampling) else $error("sampling not ended");
  a_channel_count_sel_hidden: assert property (@(posedge clock) disable iff (!reset_n)
    res12 |-> channel_count_sel_eff == 2'h0) else $error("channel count visible in 12-bit mode");
  a_rc_ignores_div: assert property (@(posedge clock) disable iff (!reset_n)
    con3_reg[sac_pkg::BIT_RC] |-> tad_tick == rc_tick) else $error("RC clock not used");
  a_div_bound: assert property (@(posedge clock) disable iff (!reset_n)
    tad_cnt_reg <= sac_pkg::DIV_MAX) else $error("divider overrun");
  a_dma_step_rate: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end && increment_rate_field_cnt_reg != con2_reg[5:2] |=> !dma_step) else $error("early DMA step");
  a_ref_high: assert property (@(posedge clock) disable iff (!reset_n)
    con2_reg[15] |=> !ext_ref_pos && !ext_ref_neg) else $error("reserved reference not default");
  a_dma_step_due: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end && increment_rate_field_cnt_reg == con2_reg[5:2] |=> dma_step) else $error("DMA step missed");
  a_done_cleared: assert property (@(posedge clock) disable iff (!reset_n)
    start_conv |=> !done_reg) else $error("done not cleared at start");
  a_buffer_half_status_unsplit: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end && !con2_reg[sac_pkg::BIT_SPLIT_BUFFER_MODE] |=> !buffer_half_status_reg) else $error("buffer half moved in plain mode");
  a_buffer_half_status_toggle: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end && increment_rate_field_cnt_reg == con2_reg[5:2] && con2_reg[sac_pkg::BIT_SPLIT_BUFFER_MODE] |=> buffer_half_status_reg != $past(buffer_half_status_reg))
    else $error("buffer half not swapped");
  a_alt_toggle: assert property (@(posedge clock) disable iff (!reset_n)
    conv_end && con2_reg[sac_pkg::BIT_ALTERNATE_SAMPLE_MODE] |=> alt_b_reg != $past(alt_b_reg)) else $error("sample set not swapped");
  a_single_12b: assert property (@(posedge clock) disable iff (!reset_n)
    res12 |=> !simultaneous) else $error("simultaneous sampling in 12-bit mode");
  a_chs123_zero: assert property (@(posedge clock) disable iff (!reset_n)
    res12 && rd && !penable && paddr == sac_pkg::ADDR_CHS123 |=> prdata == 32'h00000000)
    else $error("channel 1-3 selects visible in 12-bit mode");
  sequence s_sw_sample_req;
    state_reg == sac_pkg::SAC_IDLE && on && sw_sampling_bit_wr && pwdata[sac_pkg::BIT_SAMPLING_BIT];
  endsequence
  a_sw_sample: assert property (@(posedge clock) disable iff (!reset_n)
    s_sw_sample_req |=> sampling_bit_reg ##1 sampling) else $error("software sample request ignored");
endmodule : sac_top

/* File: sac_far_model.sv */
/* Far-side model: trigger sources, RC conversion clock tick and a DMA
   channel that counts address steps.
   Assumes requests are driven just after the rising clock edge. */
module sac_far_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rc_on,
  input wire logic [2:0] trig_req,
  input wire logic dma_step,
  output logic rc_tick,
  output logic trig_pin,
  output logic trig_timer,
  output logic trig_pwm,
  output logic [7:0] dma_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] rc_div_reg;
  // The RC oscillator runs free while enabled; a tick every fourth clock.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rc_div_reg <= 2'h0;
    end else begin
      rc_div_reg <= rc_div_reg + 2'h1;
    end
  end
  assign rc_tick = rc_on && (rc_div_reg == 2'h3);
  assign trig_pin = trig_req[0];
  assign trig_timer = trig_req[1];
  assign trig_pwm = trig_req[2];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dma_count <= 8'h00;
    end else if (dma_step) begin
      dma_count <= dma_count + 8'h01;
    end
  end
endmodule : sac_far_model

/* File: sac_top_tb.sv */
/* Self-checking bench for the converter sequencer: registers, timing,
   input selects, triggers and DMA stepping.
   Assumes sac_pkg, sac_top and sac_far_model are compiled first. */
module sac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] scan_list = 32'h00000030;
  logic rc_on = 1'b0;
  logic [2:0] trig_req = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rc_tick, trig_pin, trig_timer, trig_pwm, sampling, converting, simultaneous;
  logic ch0_neg_input, ch123_neg_is_ref, ext_ref_pos, ext_ref_neg, dma_step, e, sim, neg;
  logic [1:0] active_channel;
  logic [4:0] ch0_pos, pos;
  logic [3:0] ch123_pos_base, ch123_neg_base, buffer_words_log;
  logic [7:0] dma_count;
  logic [15:0] q;
  logic [1:0] ach;
  int len;
  int err_total = 0;
  int n_checks = 0;
  always #12.5 clock = ~clock;
  sac_top uut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .trig_pin, .trig_timer, .trig_pwm, .rc_tick, .scan_list, .sampling, .converting, .active_channel,
    .simultaneous, .ch0_pos, .ch0_neg_input, .ch123_pos_base, .ch123_neg_base, .ch123_neg_is_ref,
    .ext_ref_pos, .ext_ref_neg, .dma_step, .buffer_words_log);
  sac_far_model far (.clock, .reset_n, .rc_on, .trig_req, .dma_step, .rc_tick, .trig_pin,
    .trig_timer, .trig_pwm, .dma_count);
  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // An idle cycle closes every transfer, so no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0000);
    chk({16'h0000, q}, {16'h0000, x});
  endtask : rd
  task automatic wt(input logic conv, input logic lvl);
    int n;
    n = 0;
    while ((conv ? converting : sampling) !== lvl && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 400), 32'h1);
  endtask : wt
  task automatic run_one(input logic [15:0] c1, input int ln);
    // The sequencer acts on the stored enable, so the module is switched on before sampling is asked for.
    wr(sac_pkg::ADDR_CON1, c1);
    wr(sac_pkg::ADDR_CON1, c1 | 16'h0002);
    wt(1'b0, 1'b1);
    chk({31'h0, sampling}, 32'h1);
    wr(sac_pkg::ADDR_CON1, c1);
    wt(1'b1, 1'b1);
    pos = ch0_pos;
    neg = ch0_neg_input;
    sim = simultaneous;
    len = 0;
    ach = 2'h0;
    while (converting === 1'b1 && len < 3000) begin
      if (active_channel > ach) ach = active_channel;
      @(posedge clock);
      len++;
    end
    repeat (2) @(posedge clock);
    apb(1'b0, sac_pkg::ADDR_CON1, 16'h0000);
    chk({30'h0, q[1:0]}, 32'h1);
    chk((len >= ln - ln / 6 && len <= ln + ln / 6) ? 32'(ln) : 32'(len), 32'(ln));
  endtask : run_one
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [15:0] x12 [5] = '{16'hE43F, 16'h9FFF, 16'h0007, 16'h0000, 16'h9F9F};
    logic [15:0] x10 [5] = '{16'hE73F, 16'h9FFF, 16'h0007, 16'h0707, 16'h9F9F};
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), sac_pkg::RESET_VAL);
    end
    apb(1'b0, 8'h1C, 16'h0000);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h02, 16'hFFFF);
    chk({31'h0, e}, 32'h1);
    wr(sac_pkg::ADDR_CON1, 16'h37ED);
    rd(sac_pkg::ADDR_CON1, 16'h37E4);
    for (int i = 0; i < 5; i++) begin
      wr(8'(4 * i + 4), 16'hFFFF);
      rd(8'(4 * i + 4), x12[i]);
    end
    wr(sac_pkg::ADDR_CON1, 16'h33E9);
    rd(sac_pkg::ADDR_CON1, 16'h33E8);
    for (int i = 0; i < 5; i++) begin
      wr(8'(4 * i + 4), 16'hFFFF);
      rd(8'(4 * i + 4), x10[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(8'(4 * i), 16'h0000);
    end
  endtask : t_regs
  task automatic t_mux();
    for (int i = 0; i < 8; i++) begin
      wr(sac_pkg::ADDR_CON2, {3'(i), 13'h0000});
      wr(sac_pkg::ADDR_CON4, 16'(i));
      wr(sac_pkg::ADDR_CHS123, 16'(i));
      @(posedge clock);
      chk({30'h0, ext_ref_pos, ext_ref_neg}, i[2] ? 32'h0 : {30'h0, i[0], i[1]});
      chk({28'h0, buffer_words_log}, 32'(i));
      chk({28'h0, ch123_pos_base}, i[0] ? 32'h3 : 32'h0);
      chk({27'h0, ch123_neg_is_ref, i[2] ? ch123_neg_base : 4'h0},
        {27'h0, ~i[2], i[2] ? (i[1] ? 4'h9 : 4'h6) : 4'h0});
    end
  endtask : t_mux
  task automatic t_len();
    logic [15:0] c1 [8] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8008, 16'h8008, 16'h8400, 16'h8000};
    logic [15:0] c2 [8] = '{16'h0000, 16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0100, 16'h0300, 16'h0000};
    logic [15:0] c3 [8] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8002};
    int ln [8] = '{13, 39, 26, 52, 13, 13, 15, 52};
    int ac [8] = '{0, 0, 1, 3, 0, 0, 0, 0};
    for (int i = 0; i < 8; i++) begin
      rc_on <= (i == 7);
      wr(sac_pkg::ADDR_CON1, c1[i] & 16'h7FFF);
      wr(sac_pkg::ADDR_CON2, c2[i]);
      wr(sac_pkg::ADDR_CON3, c3[i]);
      run_one(c1[i], ln[i]);
      chk({31'h0, sim}, {31'h0, c1[i][3]});
      chk({30'h0, ach}, 32'(ac[i]));
    end
    rc_on <= 1'b0;
    wr(sac_pkg::ADDR_CON1, 16'h0000);
    wr(sac_pkg::ADDR_CON3, 16'h0000);
  endtask : t_len
  task automatic t_alt();
    logic [4:0] p1;
    logic n1;
    wr(sac_pkg::ADDR_CON2, 16'h0001);
    wr(sac_pkg::ADDR_CHS0, 16'h099F);
    run_one(16'h8000, 13);
    p1 = pos;
    n1 = neg;
    run_one(16'h8000, 13);
    chk({22'h0, p1, pos}, {22'h0, 5'h1F, 5'h09});
    chk({30'h0, n1, neg}, 32'h2);
    wr(sac_pkg::ADDR_CON2, 16'h0400);
    run_one(16'h8000, 13);
    p1 = pos;
    run_one(16'h8000, 13);
    chk({22'h0, p1, pos}, {22'h0, 5'h04, 5'h05});
  endtask : t_alt
  task automatic t_trig();
    logic [2:0] src [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    wr(sac_pkg::ADDR_CON3, 16'h0800);
    for (int i = 0; i < 4; i++) begin
      wr(sac_pkg::ADDR_CON1, 16'h0000);
      wr(sac_pkg::ADDR_CON1, {8'h80, src[i], 5'h04});
      wt(1'b0, 1'b1);
      len = 0;
      while (converting !== 1'b1 && len < 20) begin
        @(posedge clock);
        len++;
      end
      chk(32'((i == 3) ? (len >= 6 && len <= 11) : (len == 20)), 32'h1);
      trig_req <= (i < 3) ? 3'(1 << i) : 3'h0;
      wt(1'b1, 1'b1);
      trig_req <= 3'h0;
      apb(1'b0, sac_pkg::ADDR_CON1, 16'h0000);
      chk({30'h0, q[1:0]}, 32'h0);
      wt(1'b1, 1'b0);
      wt(1'b0, 1'b1);
      apb(1'b0, sac_pkg::ADDR_CON1, 16'h0000);
      chk({30'h0, q[1:0]}, 32'h3);
    end
    wr(sac_pkg::ADDR_CON1, 16'h0000);
    wr(sac_pkg::ADDR_CON3, 16'h0000);
  endtask : t_trig
  task automatic t_dma();
    logic [7:0] d0;
    wr(sac_pkg::ADDR_CON2, 16'h0006);
    d0 = dma_count;
    for (int k = 1; k <= 4; k++) begin
      run_one(16'h8000, 13);
      chk({24'h0, 8'(dma_count - d0)}, 32'(k / 2));
      rd(sac_pkg::ADDR_CON2, {8'h00, 1'(k / 2 % 2), 7'h06});
    end
  endtask : t_dma
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_mux();
    t_len();
    t_alt();
    t_trig();
    t_dma();
    conclude();
  end
  // The whole run needs about a thousand clocks; forty thousand means a hang.
  initial begin
    #1000000;
    err_total++;
    conclude();
  end
endmodule : sac_top_tb
